// [shared/sleep_clock_reset_pkg.sv]
// constants shared by the sleep clock and reset control block
// Functional notes
// [RULE1] Sleep-kept peripheral stays clocked in sleep while gating is active.
// [RULE2] A kept peripheral's wake request returns the processor to run mode.
// [RULE3] Gating off: sleep settings kept stored but ignored, all peripherals run.
// [RULE4] PLL watch timer enabled raises an interrupt when the PLL stops.
// [RULE5] PLL watch uses main oscillator as reference, only checks while oscillator enabled.
// [RULE6] Software disables PLL watch during PLL reconfiguration, re-enables afterwards.
// [RULE7] PWM clock is processor clock divided by 1, 2, 4, 8, 16, 32 or 64.
// [RULE8] Selected PWM divisor reads back as the value in force.
// [RULE9] Software reset resets processor, peripherals and every register to default.
// [RULE10] Software reset keeps reset-cause record and sets its software cause bit.
// [RULE11] Each cause flag stays set until software clear or external reset.
// [RULE12] Six cause flags accumulate: regulator, software, watchdog, brown-out, power-on, external.
// [RULE13] Software clears any subset of cause flags without disturbing the others.
// [RULE14] USB PHY PLL power down stops the PHY, controller registers stay accessible.
// [RULE15] Software powers the USB PHY PLL up before any USB connection.
// [RULE16] A read-only register gives the total SRAM size in bytes.
// [RULE17] One bit per cause flag; writing one clears it, zero leaves it.
// [RULE18] PWM divisor is a 3-bit exponent; change applies at next divided-clock boundary.
// [RULE19] Gated peripheral stops in sleep and resumes with full state afterwards.
package sleep_clock_reset_pkg;
  localparam int          NUM_PERIPH        = 32;
  localparam logic [7:0]  OFS_SLEEP_KEEP    = 8'h00;
  localparam logic [7:0]  OFS_GATING        = 8'h04;
  localparam logic [7:0]  OFS_PLL_WATCH     = 8'h08;
  localparam logic [7:0]  OFS_PWM_DIV       = 8'h0C;
  localparam logic [7:0]  OFS_SOFT_RESET    = 8'h10;
  localparam logic [7:0]  OFS_RESET_REASON  = 8'h14;
  localparam logic [7:0]  OFS_USB_PLL       = 8'h18;
  localparam logic [7:0]  OFS_SRAM_SIZE     = 8'h1C;
  localparam logic [7:0]  OFS_INT_STATUS    = 8'h20;
  localparam logic [7:0]  OFS_INT_MASK      = 8'h24;
  localparam logic [7:0]  OFS_WAKE_STATUS   = 8'h28;
  // reset reason bit positions
  localparam int          BIT_EXTERNAL      = 0;
  localparam int          BIT_POWERON       = 1;
  localparam int          BIT_BROWNOUT      = 2;
  localparam int          BIT_WATCHDOG      = 3;
  localparam int          BIT_SOFTWARE      = 4;
  localparam int          BIT_REGULATOR     = 5;
  localparam int          NUM_CAUSES        = 6;
  // interrupt status bit positions
  localparam int          INT_PLL_LOST      = 0;
  localparam int          INT_WAKE          = 1;
  localparam int          NUM_INTS          = 2;
  localparam logic [2:0]  PWM_DIV_RESET     = 3'h0;
  localparam logic [2:0]  PWM_DIV_MAX       = 3'h6;
  // pll watch: pll edges expected within this many oscillator edges
  localparam logic [7:0]  PLL_WATCH_WINDOW  = 8'h10;
  // software reset pulse length in system clocks
  localparam logic [3:0]  SOFT_RESET_CYCLES = 4'h8;
  localparam logic [31:0] SRAM_SIZE_BYTES   = 32'h0001_0000;
  localparam logic [31:0] SOFT_RESET_KEY    = 32'h0000_0001;
endpackage : sleep_clock_reset_pkg

// [rtl/pwm_clock_divider.sv]
// power-of-two divider producing the pwm clock enable
`timescale 1ns/1ns
module pwm_clock_divider (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // control
  input  wire logic [2:0] divSelect,
  // status
  output logic [2:0]      divInForce,
  output logic            pwmTick
);
  logic [5:0] count;
  logic [5:0] limit;

  assign limit = 6'((7'h1 << divInForce) - 7'h1);

  // new exponent latched only at a boundary so no short period appears
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count      <= 6'h00;
      divInForce <= sleep_clock_reset_pkg::PWM_DIV_RESET;
      pwmTick    <= 1'b0;
    end else if (count >= limit) begin // RULE18
      count      <= 6'h00;
      divInForce <= divSelect; // RULE18
      pwmTick    <= 1'b1; // RULE7
    end else begin
      count   <= 6'(count + 6'h01);
      pwmTick <= 1'b0;
    end
  end

  AST_TICK_SPACING: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pwmTick && divInForce == 3'h1) |=> !pwmTick ##1 pwmTick) // RULE7
    else $error("pwm tick spacing wrong for divide by two");
  AST_DIV_ONE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pwmTick && divInForce == 3'h0 && $stable(divInForce)) |=> pwmTick) // RULE7
    else $error("divide by one must tick every cycle");
endmodule : pwm_clock_divider

// [rtl/sleep_clock_reset_control.sv]
// system control: sleep gating, pll watch, pwm clock, resets and causes
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module sleep_clock_reset_control (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // axi4-lite write address
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // processor sleep and wake
  input  wire logic                   cpuSleeping,
  input  wire logic [31:0]            periphWakeRequest,
  output logic                        cpuWake,
  output logic [31:0]                 periphClockEnable,
  // pll watch, pins from other clock sources
  input  wire logic                   pllClockPin,
  input  wire logic                   mainOscPin,
  input  wire logic                   mainOscEnabled,
  // reset sources, pulses from the reset generator; software reset pulse out
  input  wire logic                   externalResetEvent,
  input  wire logic                   poweronResetEvent,
  input  wire logic                   brownoutResetEvent,
  input  wire logic                   watchdogResetEvent,
  input  wire logic                   regulatorResetEvent,
  output logic                        whole_chip_soft_reset,
  // pwm clock
  output logic                        pwmClockTick,
  // usb phy
  output logic                        usbPhyPllPowered,
  // interrupt
  output logic                        irq
);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [31:0] sleep_clock_keep_request;
  logic        sleep_gating_global_enable;
  logic        pll_watch_timer_control;
  logic [2:0]  pwm_divider_select;
  logic [2:0]  pwmDivInForce;
  logic [5:0]  resetReason;
  logic        usbPllOn;
  logic [1:0]  intStatus;
  logic [1:0]  intMask;
  logic [3:0]  softCount;
  logic        softActive;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        awHeld;
  logic        wHeld;
  logic        doWrite;
  logic        regRstn;
  logic [31:0] wakeLatched;
  logic        pllLost;
  logic        wakeEvent;

  // registers see software reset as well as the reset input
  assign regRstn = rstn && !softActive; // RULE9

  function automatic logic known_offset(input logic [7:0] a);
    known_offset = (a[1:0] == 2'h0) && (a <= sleep_clock_reset_pkg::OFS_WAKE_STATUS);
  endfunction : known_offset

  // ---------------- write channel ----------------
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_offset(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = doWrite && awAddr == ofs;
  endfunction : wr_hit

  // ---------------- control registers ----------------
  always_ff @(posedge sys_clk) begin
    if (!regRstn) begin
      sleep_clock_keep_request   <= 32'h0000_0000;
      sleep_gating_global_enable <= 1'b0;
      pll_watch_timer_control    <= 1'b0;
      pwm_divider_select         <= sleep_clock_reset_pkg::PWM_DIV_RESET;
      usbPllOn                   <= 1'b0;
      intMask                    <= 2'h0;
    end else begin
      if (wr_hit(sleep_clock_reset_pkg::OFS_SLEEP_KEEP)) begin
        for (int b = 0; b < 4; b++) begin
          if (wStrb[b]) begin
            sleep_clock_keep_request[b*8 +: 8] <= wData[b*8 +: 8];
          end
        end
      end
      if (wr_hit(sleep_clock_reset_pkg::OFS_GATING) && wStrb[0]) begin
        sleep_gating_global_enable <= wData[0];
      end
      if (wr_hit(sleep_clock_reset_pkg::OFS_PLL_WATCH) && wStrb[0]) begin
        pll_watch_timer_control <= wData[0];
      end
      // divisors above 64 are refused and the old value stays
      if (wr_hit(sleep_clock_reset_pkg::OFS_PWM_DIV) && wStrb[0]
          && wData[2:0] <= sleep_clock_reset_pkg::PWM_DIV_MAX && wData[7:3] == 5'h00) begin
        pwm_divider_select <= wData[2:0]; // RULE7
      end
      if (wr_hit(sleep_clock_reset_pkg::OFS_USB_PLL) && wStrb[0]) begin
        usbPllOn <= wData[0]; // RULE14
      end
      if (wr_hit(sleep_clock_reset_pkg::OFS_INT_MASK) && wStrb[0]) begin
        intMask <= wData[1:0];
      end
    end
  end

  // only the phy sees this; register access to usb is never gated
  assign usbPhyPllPowered = usbPllOn; // RULE14

  // ---------------- sleep gating ----------------
  genvar p;
  generate
    for (p = 0; p < sleep_clock_reset_pkg::NUM_PERIPH; p++) begin : g_gate
      // gating off: keep bits are stored but ignored
      assign periphClockEnable[p] = !cpuSleeping || !sleep_gating_global_enable // RULE3
                                    || sleep_clock_keep_request[p]; // RULE1 RULE19
    end
  endgenerate

  // wake only from peripherals actually clocked in sleep
  assign wakeLatched = periphWakeRequest & periphClockEnable;
  assign cpuWake     = cpuSleeping && (|wakeLatched); // RULE2
  assign wakeEvent   = cpuWake;

  // ---------------- pll watch ----------------
  logic [2:0] pllSync;
  logic [2:0] oscSync;
  logic [7:0] oscEdges;
  logic       watchLive;

  // two stages then an edge stage; edge logic reads stages 1 and 2 only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pllSync <= 3'h0;
      oscSync <= 3'h0;
    end else begin
      pllSync <= {pllSync[1:0], pllClockPin};
      oscSync <= {oscSync[1:0], mainOscPin};
    end
  end

  assign watchLive = pll_watch_timer_control && mainOscEnabled; // RULE5

  // count oscillator edges since the last pll edge
  always_ff @(posedge sys_clk) begin
    if (!regRstn || !watchLive) begin
      oscEdges <= 8'h00;
    end else if (pllSync[2] != pllSync[1]) begin
      oscEdges <= 8'h00;
    end else if (oscSync[2] != oscSync[1] && oscEdges != sleep_clock_reset_pkg::PLL_WATCH_WINDOW) begin
      oscEdges <= 8'(oscEdges + 8'h01); // RULE5
    end
  end
  assign pllLost = watchLive && oscEdges == sleep_clock_reset_pkg::PLL_WATCH_WINDOW; // RULE4

  // ---------------- interrupts ----------------
  logic [1:0] intEvents;
  logic [1:0] intClear;
  assign intEvents = {wakeEvent, pllLost};
  assign intClear  = (wr_hit(sleep_clock_reset_pkg::OFS_INT_STATUS) && wStrb[0]) ? wData[1:0] : 2'h0;

  // set beats a simultaneous clear
  always_ff @(posedge sys_clk) begin
    if (!regRstn) begin
      intStatus <= 2'h0;
    end else begin
      intStatus <= (intStatus & ~intClear) | intEvents; // RULE4
    end
  end

  assign irq = |(intStatus & intMask);

  // ---------------- software reset ----------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      softCount <= 4'h0;
    end else if (softCount != 4'h0) begin
      softCount <= 4'(softCount - 4'h1);
    end else if (wr_hit(sleep_clock_reset_pkg::OFS_SOFT_RESET) && wStrb[0]
                 && wData == sleep_clock_reset_pkg::SOFT_RESET_KEY) begin
      softCount <= sleep_clock_reset_pkg::SOFT_RESET_CYCLES; // RULE9
    end
  end

  assign softActive            = softCount != 4'h0;
  assign whole_chip_soft_reset = softActive; // RULE9

  // ---------------- reset reasons ----------------
  logic [5:0] causeSet;
  logic [5:0] causeClear;
  always_comb begin
    causeSet = 6'h00;
    causeSet[sleep_clock_reset_pkg::BIT_EXTERNAL]  = externalResetEvent;
    causeSet[sleep_clock_reset_pkg::BIT_POWERON]   = poweronResetEvent;
    causeSet[sleep_clock_reset_pkg::BIT_BROWNOUT]  = brownoutResetEvent;
    causeSet[sleep_clock_reset_pkg::BIT_WATCHDOG]  = watchdogResetEvent;
    causeSet[sleep_clock_reset_pkg::BIT_SOFTWARE]  = softCount == sleep_clock_reset_pkg::SOFT_RESET_CYCLES;
    causeSet[sleep_clock_reset_pkg::BIT_REGULATOR] = regulatorResetEvent;
  end
  assign causeClear = (wr_hit(sleep_clock_reset_pkg::OFS_RESET_REASON) && wStrb[0]) ? wData[5:0] : 6'h00;

  // record survives software reset but rstn clears it; an external reset wipes older causes
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      resetReason <= 6'h00;
    end else if (externalResetEvent) begin
      resetReason <= causeSet; // RULE11
    end else begin
      resetReason <= (resetReason & ~causeClear) | causeSet; // RULE10 RULE12 RULE13 RULE17
    end
  end

  // ---------------- pwm divider ----------------
  pwm_clock_divider u_pwm_div (
    .sys_clk    (sys_clk),
    .rstn       (regRstn),
    .divSelect  (pwm_divider_select),
    .divInForce (pwmDivInForce),
    .pwmTick    (pwmClockTick)
  );

  // ---------------- read channel ----------------
  logic [31:0] rdValue;
  always_comb begin
    rdValue = 32'h0000_0000;
    unique case (s_axi_araddr)
      sleep_clock_reset_pkg::OFS_SLEEP_KEEP:   rdValue = sleep_clock_keep_request;
      sleep_clock_reset_pkg::OFS_GATING:       rdValue = {31'h0, sleep_gating_global_enable};
      sleep_clock_reset_pkg::OFS_PLL_WATCH:    rdValue = {31'h0, pll_watch_timer_control};
      sleep_clock_reset_pkg::OFS_PWM_DIV:      rdValue = {29'h0, pwmDivInForce}; // RULE8
      sleep_clock_reset_pkg::OFS_RESET_REASON: rdValue = {26'h0, resetReason};
      sleep_clock_reset_pkg::OFS_USB_PLL:      rdValue = {31'h0, usbPllOn};
      sleep_clock_reset_pkg::OFS_SRAM_SIZE:    rdValue = sleep_clock_reset_pkg::SRAM_SIZE_BYTES; // RULE16
      sleep_clock_reset_pkg::OFS_INT_STATUS:   rdValue = {30'h0, intStatus};
      sleep_clock_reset_pkg::OFS_INT_MASK:     rdValue = {30'h0, intMask};
      sleep_clock_reset_pkg::OFS_WAKE_STATUS:  rdValue = periphWakeRequest;
      default:                                 rdValue = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdValue;
      s_axi_rresp  <= known_offset(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- assertions ----------------
  AST_KEEP_CLOCKED: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cpuSleeping && sleep_gating_global_enable && sleep_clock_keep_request[0]) |-> periphClockEnable[0]) // RULE1
    else $error("kept peripheral lost its clock in sleep");
  AST_WAKE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cpuSleeping && (periphWakeRequest[0] && periphClockEnable[0])) |-> cpuWake) // RULE2
    else $error("wake request from running peripheral ignored");
  AST_GATING_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    !sleep_gating_global_enable |-> (&periphClockEnable)) // RULE3
    else $error("peripheral gated while gating disabled");
  AST_GATED_STOP: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cpuSleeping && sleep_gating_global_enable && !sleep_clock_keep_request[1]) |-> !periphClockEnable[1]) // RULE19
    else $error("unkept peripheral still clocked in sleep");
  AST_PLL_INT: assert property (@(posedge sys_clk) disable iff (!regRstn)
    pllLost |=> intStatus[0]) // RULE4
    else $error("pll loss did not set status");
  AST_WATCH_NEEDS_OSC: assert property (@(posedge sys_clk) disable iff (!rstn)
    !mainOscEnabled |-> !pllLost) // RULE5
    else $error("pll loss flagged without oscillator");
  AST_SOFT_CAUSE: assert property (@(posedge sys_clk) disable iff (!rstn)
    ($rose(softActive) && !externalResetEvent) |=> resetReason[sleep_clock_reset_pkg::BIT_SOFTWARE]) // RULE10
    else $error("software reset cause not recorded");
  AST_CAUSE_STICKY: assert property (@(posedge sys_clk) disable iff (!rstn)
    (resetReason[3] && !externalResetEvent && causeClear[3] == 1'b0) |=> resetReason[3]) // RULE11
    else $error("watchdog cause dropped without clear");
  AST_CAUSE_CLEAR: assert property (@(posedge sys_clk) disable iff (!rstn)
    (causeClear[2] && !brownoutResetEvent && !externalResetEvent) |=> !resetReason[2]) // RULE13
    else $error("brownout cause not cleared");
  AST_SOFT_LEN: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(softActive) |-> softActive [*8] ##1 !softActive) // RULE9
    else $error("software reset pulse length wrong");
  AST_USB: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_hit(sleep_clock_reset_pkg::OFS_USB_PLL) && wStrb[0] && !softActive) |=> usbPhyPllPowered == $past(wData[0])) // RULE14
    else $error("usb pll power did not follow write");
  AST_DIV_RANGE: assert property (@(posedge sys_clk) disable iff (!rstn)
    pwmDivInForce <= sleep_clock_reset_pkg::PWM_DIV_MAX) // RULE18
    else $error("pwm divisor exponent out of range");

  COV_SLEEP_WAKE: cover property (@(posedge sys_clk) disable iff (!rstn) cpuSleeping ##1 cpuWake);
  COV_PLL_LOST:   cover property (@(posedge sys_clk) disable iff (!rstn) pllLost && irq);
  COV_SOFT_RST:   cover property (@(posedge sys_clk) disable iff (!rstn) $rose(softActive));
  COV_TWO_CAUSES: cover property (@(posedge sys_clk) disable iff (!rstn) resetReason[3] && resetReason[4]);
endmodule : sleep_clock_reset_control

// [sim/testbench.sv]
// self-checking bench for the sleep clock and reset control block
`timescale 1ns/1ns
module testbench;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, cpuWake, softRst, tick, usbPwr, irq;
  logic [31:0] rdata, pce;
  logic [1:0]  bresp, rresp, rs;
  logic        sleeping = 1'b0, oscEn = 1'b0, pllRun = 1'b1, mainOsc = 1'b0, pllPin = 1'b0;
  logic [31:0] wake = 32'h0;
  logic [4:0]  ev = 5'h0;
  logic [1:0]  oscDiv = 2'h0;
  int          n_fail = 0, comparisons = 0, cyc = 0, lastT = 0, gap = 0, srRun = 0, srLast = 0;

  sleep_clock_reset_control dut_u (.sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpuSleeping(sleeping), .periphWakeRequest(wake), .cpuWake(cpuWake), .periphClockEnable(pce),
    .pllClockPin(pllPin), .mainOscPin(mainOsc), .mainOscEnabled(oscEn),
    .externalResetEvent(ev[0]), .poweronResetEvent(ev[1]), .brownoutResetEvent(ev[2]),
    .watchdogResetEvent(ev[3]), .regulatorResetEvent(ev[4]), .whole_chip_soft_reset(softRst),
    .pwmClockTick(tick), .usbPhyPllPowered(usbPwr), .irq(irq));

  initial forever #25 sys_clk = ~sys_clk;

  // oscillator and pll pins, plus tick spacing and soft reset length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    oscDiv <= oscDiv + 2'h1;
    mainOsc <= oscDiv[1];
    pllPin <= pllRun & oscDiv[0];
    if (tick) begin
      gap <= cyc - lastT;
      lastT <= cyc;
    end
    if (softRst) srRun <= srRun + 1;
    else if (srRun != 0) begin
      srLast <= srRun;
      srRun <= 0;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : step

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 60);
    chk("bvalid", 32'h1, {31'h0, bvalid});
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 60);
    chk(what, exp, rdata);
    rready <= 1'b0;
  endtask : rdc

  task automatic pulse(input logic [4:0] v);
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 5'h0;
  endtask : pulse

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // cut a hang short well beyond the few thousand cycles the tests need
  initial begin
    step(40000);
    n_fail++;
    summarize();
  end

  initial begin
    step(12);
    rstn <= 1'b1;
    rdc("sram size", sleep_clock_reset_pkg::OFS_SRAM_SIZE, sleep_clock_reset_pkg::SRAM_SIZE_BYTES);
    chk("read resp", 32'h0, {30'h0, rresp});
    wr(sleep_clock_reset_pkg::OFS_SRAM_SIZE, 32'h0);
    rdc("sram size kept", sleep_clock_reset_pkg::OFS_SRAM_SIZE, sleep_clock_reset_pkg::SRAM_SIZE_BYTES);
    wr(8'h40, 32'h1);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    rdc("unmapped read", 8'h40, 32'h0);
    chk("unmapped read resp", 32'h2, {30'h0, rresp});
    rdc("pwm reset", sleep_clock_reset_pkg::OFS_PWM_DIV, {29'h0, sleep_clock_reset_pkg::PWM_DIV_RESET});
    for (int d = 0; d <= 6; d++) begin
      wr(sleep_clock_reset_pkg::OFS_PWM_DIV, d);
      step(160);
      rdc("pwm div", sleep_clock_reset_pkg::OFS_PWM_DIV, d);
      chk("pwm gap", 32'h1 << d, gap);
    end
    wr(sleep_clock_reset_pkg::OFS_PWM_DIV, 32'h7);
    step(160);
    rdc("pwm div ignored", sleep_clock_reset_pkg::OFS_PWM_DIV, 32'h6);
    chk("pwm gap max", 32'h40, gap);
    wr(sleep_clock_reset_pkg::OFS_SLEEP_KEEP, 32'h5);
    wr(sleep_clock_reset_pkg::OFS_GATING, 32'h1);
    sleeping <= 1'b1;
    step(2);
    chk("sleep clocks", 32'h5, pce);
    wake <= 32'h2;
    step(2);
    chk("gated wake", 32'h0, {31'h0, cpuWake});
    wake <= 32'h4;
    step(2);
    chk("kept wake", 32'h1, {31'h0, cpuWake});
    rdc("wake raw", sleep_clock_reset_pkg::OFS_WAKE_STATUS, 32'h4);
    wake <= 32'h2;
    wr(sleep_clock_reset_pkg::OFS_GATING, 32'h0);
    chk("ungated clocks", 32'hFFFF_FFFF, pce);
    chk("ungated wake", 32'h1, {31'h0, cpuWake});
    rdc("keep stored", sleep_clock_reset_pkg::OFS_SLEEP_KEEP, 32'h5);
    sleeping <= 1'b0;
    wake <= 32'h0;
    rdc("wake status", sleep_clock_reset_pkg::OFS_INT_STATUS, 32'h2);
    wr(sleep_clock_reset_pkg::OFS_INT_STATUS, 32'h3);
    wr(sleep_clock_reset_pkg::OFS_INT_MASK, 32'h1);
    wr(sleep_clock_reset_pkg::OFS_PLL_WATCH, 32'h1);
    pllRun <= 1'b0;
    step(200);
    rdc("watch without osc", sleep_clock_reset_pkg::OFS_INT_STATUS, 32'h0);
    oscEn <= 1'b1;
    step(200);
    rdc("pll lost", sleep_clock_reset_pkg::OFS_INT_STATUS, 32'h1);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(sleep_clock_reset_pkg::OFS_PLL_WATCH, 32'h0);
    wr(sleep_clock_reset_pkg::OFS_INT_STATUS, 32'h1);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(sleep_clock_reset_pkg::OFS_USB_PLL, 32'h1);
    chk("usb pll on", 32'h1, {31'h0, usbPwr});
    wr(sleep_clock_reset_pkg::OFS_USB_PLL, 32'h0);
    chk("usb pll off", 32'h0, {31'h0, usbPwr});
    wr(sleep_clock_reset_pkg::OFS_RESET_REASON, 32'h3F);
    pulse(5'b11110);
    rdc("causes", sleep_clock_reset_pkg::OFS_RESET_REASON, 32'h2E);
    wr(sleep_clock_reset_pkg::OFS_RESET_REASON, 32'h8);
    rdc("cause cleared", sleep_clock_reset_pkg::OFS_RESET_REASON, 32'h26);
    wr(sleep_clock_reset_pkg::OFS_GATING, 32'h1);
    wr(sleep_clock_reset_pkg::OFS_SOFT_RESET, sleep_clock_reset_pkg::SOFT_RESET_KEY);
    step(20);
    chk("soft reset length", 32'h8, srLast);
    rdc("cause soft", sleep_clock_reset_pkg::OFS_RESET_REASON, 32'h36);
    rdc("gating default", sleep_clock_reset_pkg::OFS_GATING, 32'h0);
    rdc("mask default", sleep_clock_reset_pkg::OFS_INT_MASK, 32'h0);
    pulse(5'b00001);
    rdc("cause external", sleep_clock_reset_pkg::OFS_RESET_REASON, 32'h1);
    summarize();
  end
endmodule : testbench
